// ---- testbench/gpio_monitor.sv ----
`timescale 1ns/1ps
module gpio_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Register port
	input wire gpio_pkg::io_addr_t io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_write,
	input wire logic io_read,
	input wire logic [7:0] io_rdata,
	input wire logic bit_set_instruction,
	input wire logic bit_clear_instruction,
	input wire logic [2:0] bit_index,
	// Pins
	input wire logic [7:0] port_a_pin_oe,
	input wire logic [7:0] port_b_pin_in,
	input wire logic [7:0] port_b_pin_oe,
	input wire logic [7:0] port_c_pin_out,
	input wire logic counter0_count_input
);
	import gpio_pkg::*;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	rd_idle_a: assert property (!$past(io_read) |-> io_rdata == 8'h00)
		else $error("read data not idle");
	dir_write_a: assert property (io_write && io_addr == PORT_A_DIRECTION
		|-> ##2 port_a_pin_oe == $past(io_wdata, 2)) else $error("direction not driven");
	latch_write_a: assert property (io_write && io_addr == PORT_C_OUTPUT_LATCH
		|-> ##2 port_c_pin_out == $past(io_wdata, 2)) else $error("latch not driven");
	bit_set_a: assert property (bit_set_instruction && !io_write
		&& io_addr == PORT_A_DIRECTION |-> ##2 port_a_pin_oe ==
		($past(port_a_pin_oe) | (8'h01 << $past(bit_index, 2)))) else $error("bit set wrong");
	bit_clear_a: assert property (bit_clear_instruction && !bit_set_instruction
		&& !io_write && io_addr == PORT_C_OUTPUT_LATCH |-> ##2 port_c_pin_out ==
		($past(port_c_pin_out) & ~(8'h01 << $past(bit_index, 2)))) else $error("bit clear wrong");
	pin_ro_a: assert property (io_write && io_addr == PORT_B_PIN_LEVELS
		|-> ##2 $stable(port_b_pin_oe)) else $error("pin level write took effect");
	count_in_a: assert property (port_b_pin_in[0] [*4] |-> counter0_count_input)
		else $error("count input not following pin");
	// Reset must not gate this check, since it is the reset behaviour itself.
	float_a: assert property (disable iff (1'b0) !reset_n |-> port_a_pin_oe == 8'h00)
		else $error("pin driven in reset");
endmodule // gpio_monitor

// ---- testbench/pin_board.sv ----
`timescale 1ns/1ps
module pin_board (
	// Device side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Board side
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_in
);
	// No pull-ups exist, so an undriven pin shows whatever the board puts on it.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_board

// ---- testbench/test_triple_byte_gpio_ports.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module test_triple_byte_gpio_ports;
	import gpio_pkg::*;
	logic sys_clk = 1'b0;
	logic clk_on = 1'b1;
	// Reset falls just after time zero so the asynchronous pin release sees a real edge.
	logic reset_n = 1'b1;
	io_addr_t io_addr = 6'h00;
	port_byte_t io_wdata = 8'h00, io_rdata;
	logic io_write = 1'b0, io_read = 1'b0, bit_set_instruction = 1'b0;
	logic bit_clear_instruction = 1'b0;
	logic [2:0] bit_index = 3'h0;
	wire port_byte_t p_in [3], p_out [3], p_oe [3];
	port_byte_t ext [3] = '{8'h00, 8'h00, 8'h00};
	logic spi_enable = 1'b0, spi_master = 1'b0, spi_mosi_drive = 1'b0;
	logic spi_miso_drive = 1'b0, spi_sck_drive = 1'b0;
	logic spi_ss_level, spi_mosi_level, spi_miso_level, spi_sck_level;
	logic counter0_count_input, counter1_count_input;
	int n_errors = 0, tests_run = 0;
	// The clock can be halted to show that reset needs no edge.
	always #10 if (clk_on) sys_clk = ~sys_clk;
	triple_byte_gpio_ports dut (.sys_clk, .reset_n, .io_addr, .io_wdata, .io_write, .io_read,
		.io_rdata, .bit_set_instruction, .bit_clear_instruction, .bit_index,
		.port_a_pin_in(p_in[0]), .port_a_pin_out(p_out[0]), .port_a_pin_oe(p_oe[0]),
		.port_b_pin_in(p_in[1]), .port_b_pin_out(p_out[1]), .port_b_pin_oe(p_oe[1]),
		.port_c_pin_in(p_in[2]), .port_c_pin_out(p_out[2]), .port_c_pin_oe(p_oe[2]),
		.spi_enable, .spi_master, .spi_mosi_drive, .spi_miso_drive, .spi_sck_drive,
		.spi_ss_level, .spi_mosi_level, .spi_miso_level, .spi_sck_level,
		.counter0_count_input, .counter1_count_input);
	for (genvar i = 0; i < 3; i++) begin : g_pins
		pin_board board (.pin_out(p_out[i]), .pin_oe(p_oe[i]), .ext_level(ext[i]),
			.pin_in(p_in[i]));
	end
	task automatic wr(input io_addr_t a, input port_byte_t d);
		@(posedge sys_clk);
		io_write <= 1'b1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge sys_clk);
		io_write <= 1'b0;
	endtask
	task automatic rd(input io_addr_t a, output port_byte_t d);
		@(posedge sys_clk);
		io_read <= 1'b1;
		io_addr <= a;
		@(posedge sys_clk);
		io_read <= 1'b0;
		#1 d = io_rdata;
	endtask
	task automatic bop(input logic s, input io_addr_t a, input logic [2:0] i);
		@(posedge sys_clk);
		bit_set_instruction <= s;
		bit_clear_instruction <= !s;
		io_addr <= a;
		bit_index <= i;
		@(posedge sys_clk);
		bit_set_instruction <= 1'b0;
		bit_clear_instruction <= 1'b0;
	endtask
	task automatic t_map();
		port_byte_t d;
		for (int p = 0; p < 3; p++) begin
			ext[p] <= 8'h3c;
			wr(LATCH_ADDR[p], 8'ha5 ^ 8'(p));
			wr(DIRECTION_ADDR[p], 8'h0f);
			wr(PIN_LEVELS_ADDR[p], 8'hff);
			rd(LATCH_ADDR[p], d);
			`CHK("latch", 8'ha5 ^ 8'(p), d)
			rd(DIRECTION_ADDR[p], d);
			`CHK("direction", 8'h0f, d)
			`CHK("oe", 8'h0f, p_oe[p])
			`CHK("out", 8'ha5 ^ 8'(p), p_out[p])
			rd(PIN_LEVELS_ADDR[p], d);
			`CHK("pins", ((8'ha5 ^ 8'(p)) & 8'h0f) | 8'h30, d)
		end
		rd(6'h3f, d);
		`CHK("unmapped", 8'h00, d)
		$display("map test done");
	endtask
	task automatic t_bits();
		port_byte_t d;
		wr(PORT_A_DIRECTION, 8'h00);
		for (int i = 0; i < 8; i++) begin
			bop(1'b1, PORT_A_DIRECTION, 3'(i));
			rd(PORT_A_DIRECTION, d);
			`CHK("bit set", 8'hff >> (7 - i), d)
		end
		wr(PORT_C_OUTPUT_LATCH, 8'hff);
		for (int i = 7; i >= 0; i--) begin
			bop(1'b0, PORT_C_OUTPUT_LATCH, 3'(i));
			rd(PORT_C_OUTPUT_LATCH, d);
			`CHK("bit clear", 8'hff >> (8 - i), d)
		end
		bop(1'b1, PORT_C_PIN_LEVELS, 3'h0);
		rd(PORT_C_OUTPUT_LATCH, d);
		`CHK("pin level bit op", 8'h00, d)
		$display("bit test done");
	endtask
	task automatic t_alt();
		wr(PORT_B_DIRECTION, 8'ha0);
		wr(PORT_B_OUTPUT_LATCH, 8'h00);
		ext[1] <= 8'h51;
		spi_enable <= 1'b1;
		spi_master <= 1'b1;
		spi_mosi_drive <= 1'b1;
		spi_sck_drive <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 `CHK("master", 7'b1011111, {counter0_count_input, counter1_count_input,
			spi_ss_level, spi_mosi_level, spi_miso_level, spi_sck_level, p_out[1][5]})
		wr(PORT_B_DIRECTION, 8'h40);
		ext[1] <= 8'ha2;
		spi_master <= 1'b0;
		spi_miso_drive <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 `CHK("slave", 7'b0101111, {counter0_count_input, counter1_count_input,
			spi_ss_level, spi_mosi_level, spi_miso_level, spi_sck_level, p_out[1][6]})
		spi_enable <= 1'b0;
		$display("alternate test done");
	endtask
	task automatic t_reset();
		port_byte_t d;
		for (int p = 0; p < 3; p++) wr(DIRECTION_ADDR[p], 8'hff);
		@(posedge sys_clk);
		#5 clk_on = 1'b0;
		#20 reset_n <= 1'b0;
		#5 `CHK("float", 24'h000000, {p_oe[0], p_oe[1], p_oe[2]})
		clk_on = 1'b1;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(PORT_A_OUTPUT_LATCH, d);
		`CHK("latch reset", LATCH_RESET, d)
		rd(PORT_A_DIRECTION, d);
		`CHK("direction reset", DIRECTION_RESET, d)
		$display("reset test done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#40000;
		n_errors++;
		close_out();
	end
	initial begin
		#1 reset_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_map();
		t_bits();
		t_alt();
		t_reset();
		close_out();
	end
endmodule // test_triple_byte_gpio_ports
bind triple_byte_gpio_ports gpio_monitor mon (.sys_clk, .reset_n, .io_addr, .io_wdata,
	.io_write, .io_read, .io_rdata, .bit_set_instruction, .bit_clear_instruction, .bit_index,
	.port_a_pin_oe, .port_b_pin_in, .port_b_pin_oe, .port_c_pin_out, .counter0_count_input);

// ---- verilog/gpio_pkg.sv ----
package gpio_pkg;

	localparam int PORT_COUNT = 3;
	localparam int PORT_WIDTH = 8;
	localparam int ADDR_WIDTH = 6;
	localparam int BIT_INDEX_WIDTH = 3;

	typedef logic [ADDR_WIDTH-1:0] io_addr_t;
	typedef logic [PORT_WIDTH-1:0] port_byte_t;

	// Port index within the packed arrays: A, B, C.
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;

	localparam io_addr_t PORT_A_OUTPUT_LATCH = 6'h1b;
	localparam io_addr_t PORT_A_DIRECTION = 6'h1a;
	localparam io_addr_t PORT_A_PIN_LEVELS = 6'h19;
	localparam io_addr_t PORT_B_OUTPUT_LATCH = 6'h18;
	localparam io_addr_t PORT_B_DIRECTION = 6'h17;
	localparam io_addr_t PORT_B_PIN_LEVELS = 6'h16;
	localparam io_addr_t PORT_C_OUTPUT_LATCH = 6'h15;
	localparam io_addr_t PORT_C_DIRECTION = 6'h14;
	localparam io_addr_t PORT_C_PIN_LEVELS = 6'h13;

	localparam io_addr_t LATCH_ADDR [PORT_COUNT] = '{
		PORT_A_OUTPUT_LATCH, PORT_B_OUTPUT_LATCH, PORT_C_OUTPUT_LATCH};
	localparam io_addr_t DIRECTION_ADDR [PORT_COUNT] = '{
		PORT_A_DIRECTION, PORT_B_DIRECTION, PORT_C_DIRECTION};
	localparam io_addr_t PIN_LEVELS_ADDR [PORT_COUNT] = '{
		PORT_A_PIN_LEVELS, PORT_B_PIN_LEVELS, PORT_C_PIN_LEVELS};

	localparam port_byte_t LATCH_RESET = 8'h00;
	localparam port_byte_t DIRECTION_RESET = 8'h00;
	localparam port_byte_t READ_IDLE = 8'h00;

	// Port B alternate function bit positions.
	localparam int COUNTER0_BIT = 0;
	localparam int COUNTER1_BIT = 1;
	localparam int SPI_SS_BIT = 4;
	localparam int SPI_MOSI_BIT = 5;
	localparam int SPI_MISO_BIT = 6;
	localparam int SPI_SCK_BIT = 7;

endpackage

// ---- verilog/gpio_port_slice.sv ----
`timescale 1ns/1ps
module gpio_port_slice #(
	parameter int WIDTH = gpio_pkg::PORT_WIDTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe,
	// Decoder side
	port_ctrl_if.port ctl
);
	import gpio_pkg::*;

	logic [WIDTH-1:0] latch;
	logic [WIDTH-1:0] dir;
	logic [WIDTH-1:0] sync_first;
	logic [WIDTH-1:0] sync_second;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			latch <= WIDTH'(LATCH_RESET);
		end else if (ctl.latch_we) begin
			latch <= ctl.next_latch;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			dir <= WIDTH'(DIRECTION_RESET);
		end else if (ctl.dir_we) begin
			dir <= ctl.next_dir;
		end
	end

	// Pins are asynchronous to sys_clk, so two stages before anyone looks.
	always_ff @(posedge sys_clk) begin
		sync_first <= pin_in;
		sync_second <= sync_first;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pin_out <= '0;
		end else begin
			pin_out <= (latch & ~ctl.alt_mask) | (ctl.alt_value & ctl.alt_mask); // [RQ7]
		end
	end

	// The enable clears on reset without a clock edge, so a board whose clock
	// is stopped still sees every pin released.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_oe <= '0; // [RQ9]
		end else begin
			pin_oe <= dir; // [RQ7]
		end
	end

	assign ctl.latch = latch;
	assign ctl.dir = dir;
	assign ctl.pins = sync_second;

endmodule // gpio_port_slice

// ---- verilog/port_ctrl_if.sv ----
`timescale 1ns/1ps
interface port_ctrl_if #(parameter int WIDTH = gpio_pkg::PORT_WIDTH);
	// Register updates from the decoder.
	logic latch_we;
	logic [WIDTH-1:0] next_latch;
	logic dir_we;
	logic [WIDTH-1:0] next_dir;
	// Alternate function override of the driven level.
	logic [WIDTH-1:0] alt_mask;
	logic [WIDTH-1:0] alt_value;
	// State seen by the decoder.
	logic [WIDTH-1:0] latch;
	logic [WIDTH-1:0] dir;
	logic [WIDTH-1:0] pins;

	modport ctrl (
		output latch_we, next_latch, dir_we, next_dir, alt_mask, alt_value,
		input latch, dir, pins
	);
	modport port (
		input latch_we, next_latch, dir_we, next_dir, alt_mask, alt_value,
		output latch, dir, pins
	);
endinterface

// ---- verilog/triple_byte_gpio_ports.sv ----
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] A bit set or bit clear changes one pin's latch or direction bit and leaves the rest.
// [RQ2] Ports A, B and C each have eight identical bidirectional pins.
// [RQ3] Latch and direction read and write; the pin-level address is read only.
// [RQ4] Port A sits at latch 0x1b, direction 0x1a, pin levels 0x19.
// [RQ5] Port B sits at latch 0x18, direction 0x17, pin levels 0x16.
// [RQ6] Port C sits at latch 0x15, direction 0x14, pin levels 0x13.
// [RQ7] A set direction bit drives the latch level push-pull; a clear one leaves the pin floating.
// [RQ8] The latch address reads back the latch; the pin-level address reads the pins.
// [RQ9] Reset releases every pin at once, with or without a running clock.
// [RQ10] Port B bits 0 and 1 feed the two counter count inputs.
// [RQ11] Port B bits 4 to 7 carry SPI select, MOSI, MISO and clock.
// [RQ12] Software sets direction and latch of a Port B pin before its alternate use.
// [RQ13] Writes to a pin-level address change nothing.
module triple_byte_gpio_ports #(
	parameter int WIDTH = gpio_pkg::PORT_WIDTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Register port
	input wire gpio_pkg::io_addr_t io_addr,
	input wire logic [WIDTH-1:0] io_wdata,
	input wire logic io_write,
	input wire logic io_read,
	output logic [WIDTH-1:0] io_rdata,
	// Single-bit operations on the addressed register
	input wire logic bit_set_instruction,
	input wire logic bit_clear_instruction,
	input wire logic [gpio_pkg::BIT_INDEX_WIDTH-1:0] bit_index,
	// Port A pins
	input wire logic [WIDTH-1:0] port_a_pin_in,
	output logic [WIDTH-1:0] port_a_pin_out,
	output logic [WIDTH-1:0] port_a_pin_oe,
	// Port B pins
	input wire logic [WIDTH-1:0] port_b_pin_in,
	output logic [WIDTH-1:0] port_b_pin_out,
	output logic [WIDTH-1:0] port_b_pin_oe,
	// Port C pins
	input wire logic [WIDTH-1:0] port_c_pin_in,
	output logic [WIDTH-1:0] port_c_pin_out,
	output logic [WIDTH-1:0] port_c_pin_oe,
	// SPI block, same clock
	input wire logic spi_enable,
	input wire logic spi_master,
	input wire logic spi_mosi_drive,
	input wire logic spi_miso_drive,
	input wire logic spi_sck_drive,
	output logic spi_ss_level,
	output logic spi_mosi_level,
	output logic spi_miso_level,
	output logic spi_sck_level,
	// Counter count inputs
	output logic counter0_count_input,
	output logic counter1_count_input
);
	import gpio_pkg::*;

	port_ctrl_if #(.WIDTH(WIDTH)) ctl [PORT_COUNT] ();

	logic [PORT_COUNT-1:0][WIDTH-1:0] pin_in_all;
	logic [PORT_COUNT-1:0][WIDTH-1:0] pin_out_all;
	logic [PORT_COUNT-1:0][WIDTH-1:0] pin_oe_all;
	logic [PORT_COUNT-1:0][WIDTH-1:0] latch_all;
	logic [PORT_COUNT-1:0][WIDTH-1:0] dir_all;
	logic [PORT_COUNT-1:0][WIDTH-1:0] pins_all;
	logic [WIDTH-1:0] bit_mask;
	logic bit_op;
	logic [WIDTH-1:0] port_b_alt_mask;
	logic [WIDTH-1:0] port_b_alt_value;
	logic [WIDTH-1:0] next_rdata;

	assign pin_in_all[PORT_A] = port_a_pin_in;
	assign pin_in_all[PORT_B] = port_b_pin_in;
	assign pin_in_all[PORT_C] = port_c_pin_in;
	assign port_a_pin_out = pin_out_all[PORT_A];
	assign port_b_pin_out = pin_out_all[PORT_B];
	assign port_c_pin_out = pin_out_all[PORT_C];
	assign port_a_pin_oe = pin_oe_all[PORT_A];
	assign port_b_pin_oe = pin_oe_all[PORT_B];
	assign port_c_pin_oe = pin_oe_all[PORT_C];

	// One-hot mask of the addressed bit for set and clear.
	assign bit_mask = WIDTH'(1) << bit_index; // [RQ1]
	assign bit_op = bit_set_instruction | bit_clear_instruction;

	// While the SPI block is on, it drives the level of its outputs; the pin
	// only leaves the chip if software has already set its direction bit.
	// Inputs are left to the direction register, never forced.
	always_comb begin
		port_b_alt_mask = '0;
		port_b_alt_value = '0;
		if (spi_enable) begin
			if (spi_master) begin
				port_b_alt_mask[SPI_MOSI_BIT] = 1'b1; // [RQ11]
				port_b_alt_mask[SPI_SCK_BIT] = 1'b1; // [RQ11]
			end else begin
				port_b_alt_mask[SPI_MISO_BIT] = 1'b1; // [RQ11]
			end
		end
		port_b_alt_value[SPI_MOSI_BIT] = spi_mosi_drive; // [RQ11]
		port_b_alt_value[SPI_MISO_BIT] = spi_miso_drive; // [RQ11]
		port_b_alt_value[SPI_SCK_BIT] = spi_sck_drive; // [RQ11]
	end

	for (genvar k = 0; k < PORT_COUNT; k++) begin : g_port
		logic hit_latch;
		logic hit_dir;

		assign hit_latch = (io_addr == LATCH_ADDR[k]); // [RQ4] [RQ5] [RQ6]
		assign hit_dir = (io_addr == DIRECTION_ADDR[k]); // [RQ4] [RQ5] [RQ6]

		// The pin-level address is absent here, so a write to it has no target.
		assign ctl[k].latch_we = hit_latch & (io_write | bit_op); // [RQ3] [RQ13]
		assign ctl[k].dir_we = hit_dir & (io_write | bit_op); // [RQ3] [RQ13]

		always_comb begin
			if (io_write) begin
				ctl[k].next_latch = io_wdata;
				ctl[k].next_dir = io_wdata;
			end else if (bit_set_instruction) begin
				ctl[k].next_latch = ctl[k].latch | bit_mask; // [RQ1]
				ctl[k].next_dir = ctl[k].dir | bit_mask; // [RQ1]
			end else begin
				ctl[k].next_latch = ctl[k].latch & ~bit_mask; // [RQ1]
				ctl[k].next_dir = ctl[k].dir & ~bit_mask; // [RQ1]
			end
		end

		if (k == PORT_B) begin : g_alt
			assign ctl[k].alt_mask = port_b_alt_mask;
			assign ctl[k].alt_value = port_b_alt_value;
		end else begin : g_plain
			assign ctl[k].alt_mask = '0;
			assign ctl[k].alt_value = '0;
		end

		assign latch_all[k] = ctl[k].latch;
		assign dir_all[k] = ctl[k].dir;
		assign pins_all[k] = ctl[k].pins;

		gpio_port_slice #(.WIDTH(WIDTH)) u_slice ( // [RQ2]
			.sys_clk(sys_clk),
			.reset_n(reset_n),
			.pin_in(pin_in_all[k]),
			.pin_out(pin_out_all[k]),
			.pin_oe(pin_oe_all[k]),
			.ctl(ctl[k])
		);
	end

	// Unmapped addresses read as zero.
	always_comb begin
		next_rdata = READ_IDLE;
		for (int k = 0; k < PORT_COUNT; k++) begin
			if (io_addr == LATCH_ADDR[k]) begin
				next_rdata = latch_all[k]; // [RQ8]
			end
			if (io_addr == DIRECTION_ADDR[k]) begin
				next_rdata = dir_all[k]; // [RQ3]
			end
			if (io_addr == PIN_LEVELS_ADDR[k]) begin
				next_rdata = pins_all[k]; // [RQ8]
			end
		end
	end

	// Read data stand for the one cycle after the strobe, zero otherwise.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			io_rdata <= READ_IDLE;
		end else if (io_read) begin
			io_rdata <= next_rdata;
		end else begin
			io_rdata <= READ_IDLE;
		end
	end

	// Alternate inputs tap the synchronised pin levels, whatever the direction.
	assign counter0_count_input = pins_all[PORT_B][COUNTER0_BIT]; // [RQ10]
	assign counter1_count_input = pins_all[PORT_B][COUNTER1_BIT]; // [RQ10]
	assign spi_ss_level = pins_all[PORT_B][SPI_SS_BIT]; // [RQ11]
	assign spi_mosi_level = pins_all[PORT_B][SPI_MOSI_BIT]; // [RQ11]
	assign spi_miso_level = pins_all[PORT_B][SPI_MISO_BIT]; // [RQ11]
	assign spi_sck_level = pins_all[PORT_B][SPI_SCK_BIT]; // [RQ11]

endmodule // triple_byte_gpio_ports
